//--- verilog/fpb_front_panel.sv
// Front-panel buttons, power state, LEDs, watchdog and system signals.
//
// Summary of operation
// - Buttons act on edges only, after 16 ms of stable input.
// - A debounced power button press starts the power-up sequence.
// - Holding power low four seconds or more while running or asleep forces a shutdown.
// - Reset button gives a hard reset pulse that ends even if held.
// - A debounced sleep button press requests entry into sleep.
// - Lid event requests sleep while running and wake while sleeping.
// - Two-colour LED shows main colour in running, alternate in sleep.
// - Radio activity LED lights whenever the radio slot shows traffic.
// - The management controller may issue a power request like a press.
// - An active-low kick input restarts the watchdog; driven open-drain.
// - Watchdog output asserts on expiry and otherwise rests low.
// - Battery-low input is active low and sampled; driven open-drain.
// - Thermal input, active low, is reported as a thermal alarm.
// - Six general-purpose pins idle high, undriven, on their pull-up.
// - One precision-time trigger output for each of two network ports.
`timescale 1ns/1ps
module fpb_front_panel import fpb_pkg::*; #(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned RESET_CYCLES = RESET_PULSE_CYC,
  parameter int unsigned LED_CYCLES = LED_HOLD_CYC,
  parameter int unsigned WDT_CYCLES = WDT_CYC
) (
  input logic ref_clk,
  input logic srst,
  input logic ce,
  input logic lid_switch_n,
  input logic sleep_button_n,
  input logic reset_button_n,
  input logic power_button_n,
  input logic watchdog_kick_n,
  input logic battery_low_n,
  input logic thermal_alarm_n,
  input logic mgmt_power_req,
  input logic soft_off_done,
  input logic wdt_enable,
  input logic radio_traffic,
  input logic [PTP_N-1:0] ptp_event,
  input logic [GPIO_N-1:0] gpio_in,
  input logic [GPIO_N-1:0] gpio_drive_out,
  input logic [GPIO_N-1:0] gpio_drive_oe,
  output logic power_up_req,
  output logic power_action_req,
  output logic forced_shutdown,
  output logic sleep_req,
  output logic wake_req,
  output logic hard_reset,
  output logic led_main,
  output logic led_alt,
  output logic radio_activity_led,
  output logic watchdog_expired,
  output logic battery_low,
  output logic thermal_alarm,
  output logic [2:0] power_state,
  output logic [GPIO_N-1:0] gpio_out,
  output logic [GPIO_N-1:0] gpio_oe,
  output logic [GPIO_N-1:0] gpio_level,
  output logic ptp_trigger_port0,
  output logic ptp_trigger_port1
);

  // Input filtering.
  fpb_btn_if ev [NUM_IN] ();

  wire [NUM_IN-1:0] raw_in = {thermal_alarm_n, battery_low_n,
                              watchdog_kick_n, power_button_n,
                              reset_button_n, sleep_button_n,
                              lid_switch_n};

  // Lid switch and buttons get the full debounce; kick, battery-low and thermal lines only a short filter.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      fpb_debounce #(
        .CYC(gi <= IDX_PWR ? DEBOUNCE_CYCLES : EVENT_FILTER_CYC)
      ) u_db (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .raw(raw_in[gi]),
        .bo(ev[gi])
      );
    end
  endgenerate

  wire lid_fall = ev[IDX_LID].fall;
  wire sleep_fall = ev[IDX_SLEEP].fall;
  wire rst_fall = ev[IDX_RST].fall;
  wire pwr_fall = ev[IDX_PWR].fall;
  wire pwr_rise = ev[IDX_PWR].rise;
  wire kick_fall = ev[IDX_KICK].fall;

  // Power state machine.
  fpb_pstate_t state;
  fpb_pstate_t next_state;
  logic holding;
  logic hold_run;
  logic [CNT_W-1:0] hold_cnt;

  wire in_off = state == PS_OFF;
  wire in_run = state == PS_RUN;
  wire in_sleep = state == PS_SLEEP;
  wire pwr_press = pwr_fall || mgmt_power_req;
  wire long_hit = holding && (hold_cnt == CNT_W'(HOLD_CYCLES - 1));
  // A press that woke the system must not count as a short press on release.
  wire short_release = holding && hold_run && pwr_rise && !long_hit;
  wire go_up = in_off && pwr_press;
  wire go_sleep = in_run && (sleep_fall || lid_fall) && !long_hit;
  wire go_wake = in_sleep && (pwr_press || lid_fall) && !long_hit;
  wire run_action = in_run && !long_hit &&
                    (short_release || mgmt_power_req);
  wire start_hold = pwr_fall && !in_off;

  always_comb begin
    next_state = state;
    case (state)
      PS_OFF: begin
        if (go_up) begin
          next_state = PS_RUN;
        end
      end
      PS_RUN: begin
        if (long_hit || soft_off_done) begin
          next_state = PS_OFF;
        end else if (go_sleep) begin
          next_state = PS_SLEEP;
        end
      end
      PS_SLEEP: begin
        if (long_hit) begin
          next_state = PS_OFF;
        end else if (go_wake) begin
          next_state = PS_RUN;
        end
      end
      default: begin
        next_state = PS_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= PS_OFF;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Long-press timer runs from a press seen while powered.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      holding <= 1'b0;
      hold_run <= 1'b0;
      hold_cnt <= '0;
    end else if (ce) begin
      if (start_hold) begin
        holding <= 1'b1;
        hold_run <= in_run;
        hold_cnt <= '0;
      end else if (pwr_rise || long_hit) begin
        holding <= 1'b0;
        hold_cnt <= '0;
      end else if (holding) begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // Request pulses and the power LED pair.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      power_up_req <= 1'b0;
      power_action_req <= 1'b0;
      forced_shutdown <= 1'b0;
      sleep_req <= 1'b0;
      wake_req <= 1'b0;
      led_main <= 1'b0;
      led_alt <= 1'b0;
    end else if (ce) begin
      power_up_req <= go_up;
      power_action_req <= run_action;
      forced_shutdown <= long_hit;
      sleep_req <= go_sleep;
      wake_req <= go_wake;
      led_main <= next_state == PS_RUN;
      led_alt <= next_state == PS_SLEEP;
    end
  end

  assign power_state = state;

  // Hard reset pulse and radio activity LED.
  fpb_stretch #(.CYC(RESET_CYCLES)) u_rst (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .trig(rst_fall),
    .busy(hard_reset)
  );

  fpb_stretch #(.CYC(LED_CYCLES)) u_led (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .trig(radio_traffic),
    .busy(radio_activity_led)
  );

  // Watchdog; an expiry in the same cycle as a kick wins over the kick.
  logic [CNT_W-1:0] wdt_cnt;
  wire wdt_due = wdt_enable && !watchdog_expired &&
                 (wdt_cnt == CNT_W'(WDT_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdt_cnt <= '0;
      watchdog_expired <= 1'b0;
    end else if (ce) begin
      if (!wdt_enable) begin
        wdt_cnt <= '0;
        watchdog_expired <= 1'b0;
      end else if (wdt_due) begin
        wdt_cnt <= '0;
        watchdog_expired <= 1'b1;
      end else if (kick_fall) begin
        wdt_cnt <= '0;
        watchdog_expired <= 1'b0;
      end else if (!watchdog_expired) begin
        wdt_cnt <= wdt_cnt + 1'b1;
      end
    end
  end

  // Status lines, pins and time triggers.
  logic [GPIO_N-1:0] gpio_sync;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      battery_low <= 1'b0;
      thermal_alarm <= 1'b0;
      gpio_out <= '1;
      gpio_oe <= GPIO_OE_RESET;
      gpio_sync <= '1;
      gpio_level <= '1;
      ptp_trigger_port0 <= 1'b0;
      ptp_trigger_port1 <= 1'b0;
    end else if (ce) begin
      battery_low <= !ev[IDX_BATLOW].level;
      thermal_alarm <= !ev[IDX_THERM].level;
      gpio_out <= gpio_drive_out;
      gpio_oe <= gpio_drive_oe;
      gpio_sync <= gpio_in;
      gpio_level <= gpio_sync;
      ptp_trigger_port0 <= ptp_event[0];
      ptp_trigger_port1 <= ptp_event[1];
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  int unsigned rst_len;
  always_ff @(posedge ref_clk) begin
    if (srst || !hard_reset) begin
      rst_len <= 0;
    end else begin
      rst_len <= rst_len + 1;
    end
  end

  power_up_a: assert property (
    ce && in_off && pwr_fall |=> power_up_req && state == PS_RUN)
    else $error("press while off did not power up");

  forced_off_a: assert property (
    ce && long_hit |=> forced_shutdown && state == PS_OFF && !power_action_req)
    else $error("long press did not force a shutdown");

  short_press_a: assert property (
    ce && in_run && short_release && !soft_off_done && !go_sleep
    |=> power_action_req && state == PS_RUN)
    else $error("short press did not give a power action");

  reset_release_a: assert property (
    rst_len <= RESET_CYCLES + 1)
    else $error("hard reset held too long");

  sleep_entry_a: assert property (
    ce && in_run && sleep_fall && !long_hit && !soft_off_done
    |=> sleep_req && state == PS_SLEEP)
    else $error("sleep press did not enter sleep");

  lid_wake_a: assert property (
    ce && in_sleep && lid_fall && !long_hit |=> wake_req ##1 !wake_req)
    else $error("lid event did not wake once");

  led_colour_a: assert property (
    led_main == in_run && led_alt == in_sleep && !(led_main && led_alt))
    else $error("power LED does not match state");

  mgmt_press_a: assert property (
    ce && in_off && mgmt_power_req |=> power_up_req)
    else $error("management request did not power up");

  wdt_kick_a: assert property (
    ce && kick_fall && !wdt_due |=> !watchdog_expired && wdt_cnt == '0)
    else $error("kick did not restart the watchdog");

  wdt_expire_a: assert property (
    ce && wdt_due |=> watchdog_expired)
    else $error("watchdog did not expire on time");

  wdt_rest_a: assert property (
    ce && !wdt_enable |=> !watchdog_expired)
    else $error("watchdog output not at rest while disabled");

  forced_cov: cover property (long_hit ##1 forced_shutdown);
  sleep_wake_cov: cover property (sleep_req ##[1:1000] wake_req);
  reset_cov: cover property ($fell(hard_reset));
  wdt_cov: cover property ($rose(watchdog_expired));

endmodule // fpb_front_panel

//--- verilog/fpb_pkg.sv
// Shared constants and types of the front-panel power button logic.
package fpb_pkg;

  // Clock rate, timing figures each with its derived cycle count, and the event filter length in cycles.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DEBOUNCE_MS = 16;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned HOLD_S = 4;
  localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
  localparam int unsigned RESET_PULSE_MS = 1;
  localparam int unsigned RESET_PULSE_CYC = CLK_HZ / 1000 * RESET_PULSE_MS;
  localparam int unsigned LED_HOLD_MS = 50;
  localparam int unsigned LED_HOLD_CYC = CLK_HZ / 1000 * LED_HOLD_MS;
  localparam int unsigned WDT_TIMEOUT_S = 1;
  localparam int unsigned WDT_CYC = CLK_HZ * WDT_TIMEOUT_S;
  localparam int unsigned EVENT_FILTER_CYC = 2;

  // Counter widths.
  localparam int unsigned DBNC_W = 20;
  localparam int unsigned STRETCH_W = 21;
  localparam int unsigned CNT_W = 28;

  // Positions of the filtered inputs in the input vector.
  localparam int unsigned IDX_LID = 0;
  localparam int unsigned IDX_SLEEP = 1;
  localparam int unsigned IDX_RST = 2;
  localparam int unsigned IDX_PWR = 3;
  localparam int unsigned IDX_KICK = 4;
  localparam int unsigned IDX_BATLOW = 5;
  localparam int unsigned IDX_THERM = 6;
  localparam int unsigned NUM_IN = 7;

  localparam int unsigned GPIO_N = 6;
  localparam int unsigned PTP_N = 2;

  // Reset values.
  localparam logic INPUT_IDLE = 1'h1;
  localparam logic [GPIO_N-1:0] GPIO_OE_RESET = 6'h00;

  typedef enum logic [2:0] {
    PS_OFF = 3'h1,
    PS_RUN = 3'h2,
    PS_SLEEP = 3'h4
  } fpb_pstate_t;

endpackage

//--- verilog/fpb_btn_if.sv
// Filtered level and edge pulses of one front-panel or event input.
`timescale 1ns/1ps
interface fpb_btn_if;
  logic level;
  logic fall;
  logic rise;
  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface

//--- verilog/fpb_debounce.sv
// Two-stage synchroniser and stability filter for one input.
`timescale 1ns/1ps
module fpb_debounce import fpb_pkg::*; #(
  parameter int unsigned CYC = DEBOUNCE_CYC
) (
  input logic ref_clk,
  input logic srst,
  input logic ce,
  input logic raw,
  fpb_btn_if.src bo
);
  logic sync1;
  logic sync2;
  logic [DBNC_W-1:0] cnt;

  wire differs = sync2 != bo.level;
  wire settled = differs && (cnt == DBNC_W'(CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1 <= INPUT_IDLE;
      sync2 <= INPUT_IDLE;
    end else if (ce) begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= (differs && !settled) ? cnt + 1'b1 : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bo.level <= INPUT_IDLE;
      bo.fall <= 1'b0;
      bo.rise <= 1'b0;
    end else if (ce) begin
      bo.level <= settled ? sync2 : bo.level;
      bo.fall <= settled && !sync2;
      bo.rise <= settled && sync2;
    end
  end

  settled_edge_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && settled |=> bo.level == $past(sync2) && (bo.fall || bo.rise))
    else $error("filtered level did not follow a settled input");

  early_change_a: assert property (@(posedge ref_clk) disable iff (srst)
    ce && !settled |=> $stable(bo.level))
    else $error("filtered level changed before the input settled");

endmodule // fpb_debounce

//--- verilog/fpb_stretch.sv
// Turns a one-cycle trigger into a pulse of fixed length.
`timescale 1ns/1ps
module fpb_stretch import fpb_pkg::*; #(
  parameter int unsigned CYC = 1
) (
  input logic ref_clk,
  input logic srst,
  input logic ce,
  input logic trig,
  output logic busy
);
  logic [STRETCH_W-1:0] cnt;

  wire last = cnt == STRETCH_W'(1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (ce) begin
      if (trig) begin
        cnt <= STRETCH_W'(CYC);
        busy <= 1'b1;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
        busy <= !last;
      end
    end
  end

  stretch_count_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !trig && cnt != '0
    |=> cnt == $past(cnt) - 1'b1 && busy == !$past(last))
    else $error("pulse counter did not step down");

endmodule // fpb_stretch

//--- test/fpb_panel_model.sv
// Model of the switches, open-drain drivers and pads around the panel logic.
`timescale 1ns/1ps
module fpb_panel_model import fpb_pkg::*; (
  input logic [NUM_IN-1:0] pull_low,
  input logic [GPIO_N-1:0] gpio_out,
  input logic [GPIO_N-1:0] gpio_oe,
  output logic [NUM_IN-1:0] line_n,
  output logic [GPIO_N-1:0] pad
);
  // Switches and open-drain drivers only sink, so a released line sits high.
  assign line_n = ~pull_low;
  // An undriven pin floats to its standby pull-up level.
  assign pad = (gpio_oe & gpio_out) | ~gpio_oe;
endmodule // fpb_panel_model

//--- test/tb_top.sv
// Self-checking bench of the front-panel power button logic.
`timescale 1ns/1ps
module tb_top import fpb_pkg::*; ;
  localparam int D = 8;
  localparam int H = 40;
  localparam int RC = 5;
  localparam int LC = 6;
  localparam int WC = 30;
  logic ref_clk, srst, mgmt_power_req, wdt_enable, radio_traffic;
  logic ce, soft_off;
  logic [NUM_IN-1:0] pull_low, line_n;
  logic [PTP_N-1:0] ptp_event;
  logic [GPIO_N-1:0] gdo, gdoe, pad, gpio_out, gpio_oe, gpio_level;
  logic power_up_req, power_action_req, forced_shutdown, sleep_req;
  logic wake_req, hard_reset, led_main, led_alt, radio_activity_led;
  logic watchdog_expired, battery_low, thermal_alarm;
  logic ptp_trigger_port0, ptp_trigger_port1;
  logic [2:0] power_state;
  int cnt[6];
  int base[6];
  int err_total, checked, cyc;

  fpb_panel_model pm (.pull_low(pull_low), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .line_n(line_n), .pad(pad));

  fpb_front_panel #(.DEBOUNCE_CYCLES(D), .HOLD_CYCLES(H),
    .RESET_CYCLES(RC), .LED_CYCLES(LC), .WDT_CYCLES(WC)) DUT (
    .ref_clk(ref_clk), .srst(srst), .ce(ce),
    .lid_switch_n(line_n[IDX_LID]), .sleep_button_n(line_n[IDX_SLEEP]),
    .reset_button_n(line_n[IDX_RST]), .power_button_n(line_n[IDX_PWR]),
    .watchdog_kick_n(line_n[IDX_KICK]), .battery_low_n(line_n[IDX_BATLOW]),
    .thermal_alarm_n(line_n[IDX_THERM]), .mgmt_power_req(mgmt_power_req),
    .soft_off_done(soft_off), .wdt_enable(wdt_enable),
    .radio_traffic(radio_traffic), .ptp_event(ptp_event), .gpio_in(pad),
    .gpio_drive_out(gdo), .gpio_drive_oe(gdoe),
    .power_up_req(power_up_req), .power_action_req(power_action_req),
    .forced_shutdown(forced_shutdown), .sleep_req(sleep_req),
    .wake_req(wake_req), .hard_reset(hard_reset), .led_main(led_main),
    .led_alt(led_alt), .radio_activity_led(radio_activity_led),
    .watchdog_expired(watchdog_expired), .battery_low(battery_low),
    .thermal_alarm(thermal_alarm), .power_state(power_state),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_level(gpio_level),
    .ptp_trigger_port0(ptp_trigger_port0),
    .ptp_trigger_port1(ptp_trigger_port1));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Request pulses stand one cycle and the hard reset RC cycles; each is tallied at every falling edge.
  always @(negedge ref_clk) begin
    if (power_up_req === 1'b1) cnt[0]++;
    if (power_action_req === 1'b1) cnt[1]++;
    if (forced_shutdown === 1'b1) cnt[2]++;
    if (sleep_req === 1'b1) cnt[3]++;
    if (wake_req === 1'b1) cnt[4]++;
    if (hard_reset === 1'b1) cnt[5]++;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic dchk(input string what, input int k, input int exp);
    chk(what, exp, cnt[k] - base[k]);
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Holds a line low for n cycles, then lets its filter settle.
  task automatic press(input int idx, input int n);
    base = cnt;
    pull_low[idx] = 1'b1;
    cyc_n(n);
    pull_low[idx] = 1'b0;
    cyc_n(D + 6);
  endtask

  task automatic mgmt_pulse;
    base = cnt;
    mgmt_power_req = 1'b1;
    cyc_n(1);
    mgmt_power_req = 1'b0;
    cyc_n(4);
  endtask

  task automatic t_idle;
    chk("state", PS_OFF, power_state);
    chk("led_main", 1'b0, led_main);
    chk("wdog", 1'b0, watchdog_expired);
    chk("gpio_level", 6'h3f, gpio_level);
    chk("gpio_oe", 6'h00, gpio_oe);
  endtask

  task automatic t_power;
    press(IDX_PWR, D - 3);
    dchk("bounce up", 0, 0);
    press(IDX_PWR, D + 4);
    dchk("up", 0, 1);
    chk("state", PS_RUN, power_state);
    chk("led_main", 1'b1, led_main);
    chk("led_alt", 1'b0, led_alt);
    press(IDX_PWR, D + 4);
    dchk("action", 1, 1);
    chk("state", PS_RUN, power_state);
  endtask

  task automatic t_sleep_lid;
    press(IDX_SLEEP, D + 4);
    dchk("sleep", 3, 1);
    chk("state", PS_SLEEP, power_state);
    chk("led_alt", 1'b1, led_alt);
    chk("led_main", 1'b0, led_main);
    press(IDX_LID, D + 4);
    dchk("lid wake", 4, 1);
    chk("state", PS_RUN, power_state);
    press(IDX_LID, D + 4);
    dchk("lid sleep", 3, 1);
    chk("state", PS_SLEEP, power_state);
    press(IDX_PWR, D + 4);
    dchk("pwr wake", 4, 1);
    dchk("wake no action", 1, 0);
    press(IDX_LID, D + 4);
    dchk("lid sleep again", 3, 1);
    chk("state", PS_SLEEP, power_state);
  endtask

  task automatic t_mgmt_long;
    mgmt_pulse;
    dchk("mgmt wake", 4, 1);
    mgmt_pulse;
    dchk("mgmt action", 1, 1);
    press(IDX_PWR, D + H + 10);
    dchk("forced", 2, 1);
    dchk("no action", 1, 0);
    chk("state", PS_OFF, power_state);
    chk("led_main", 1'b0, led_main);
    mgmt_pulse;
    dchk("mgmt up", 0, 1);
    chk("state", PS_RUN, power_state);
  endtask

  task automatic t_reset_btn;
    base = cnt;
    pull_low[IDX_RST] = 1'b1;
    cyc_n(D + RC + 10);
    chk("hard_reset held", 1'b0, hard_reset);
    dchk("reset cycles", 5, RC);
    pull_low[IDX_RST] = 1'b0;
    cyc_n(D + 6);
  endtask

  task automatic t_wdog_events;
    wdt_enable = 1'b1;
    cyc_n(WC + 10);
    chk("wdog expired", 1'b1, watchdog_expired);
    press(IDX_KICK, 4);
    chk("wdog kicked", 1'b0, watchdog_expired);
    wdt_enable = 1'b0;
    pull_low[IDX_BATLOW] = 1'b1;
    cyc_n(6);
    chk("battery_low", 1'b1, battery_low);
    chk("thermal", 1'b0, thermal_alarm);
    pull_low[IDX_BATLOW] = 1'b0;
    pull_low[IDX_THERM] = 1'b1;
    cyc_n(6);
    chk("battery_low", 1'b0, battery_low);
    chk("thermal", 1'b1, thermal_alarm);
    pull_low[IDX_THERM] = 1'b0;
    cyc_n(6);
    chk("thermal", 1'b0, thermal_alarm);
  endtask

  task automatic t_radio_pins;
    radio_traffic = 1'b1;
    cyc_n(1);
    radio_traffic = 1'b0;
    cyc_n(2);
    chk("radio led", 1'b1, radio_activity_led);
    cyc_n(LC + 4);
    chk("radio led", 1'b0, radio_activity_led);
    gdoe = 6'h15;
    gdo = 6'h04;
    ptp_event = 2'h2;
    cyc_n(4);
    chk("gpio_oe", 6'h15, gpio_oe);
    chk("gpio_out", 6'h04, gpio_out);
    chk("gpio_level", 6'h2e, gpio_level);
    chk("ptp0", 1'b0, ptp_trigger_port0);
    chk("ptp1", 1'b1, ptp_trigger_port1);
    ptp_event = 2'h1;
    cyc_n(2);
    chk("ptp0", 1'b1, ptp_trigger_port0);
    chk("ptp1", 1'b0, ptp_trigger_port1);
  endtask

  // Clock enable low freezes the outputs; soft-off ends the running state.
  task automatic t_freeze;
    ce = 1'b0;
    ptp_event = 2'h2;
    cyc_n(3);
    chk("ptp1 frozen", 1'b0, ptp_trigger_port1);
    ce = 1'b1;
    cyc_n(2);
    chk("ptp1", 1'b1, ptp_trigger_port1);
    soft_off = 1'b1;
    cyc_n(1);
    soft_off = 1'b0;
    cyc_n(2);
    chk("soft off", PS_OFF, power_state);
    chk("led_main", 1'b0, led_main);
  endtask

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    soft_off = 1'b0;
    pull_low = '0;
    mgmt_power_req = 1'b0;
    wdt_enable = 1'b0;
    radio_traffic = 1'b0;
    ptp_event = 2'h0;
    gdo = 6'h3f;
    gdoe = 6'h00;
    cyc_n(8);
    srst = 1'b0;
    cyc_n(2);
    t_idle;
    t_power;
    t_sleep_lid;
    t_mgmt_long;
    t_reset_btn;
    t_wdog_events;
    t_radio_pins;
    t_freeze;
    wrap_up;
  end
endmodule // tb_top
